// ---- msa_pkg.sv ----
package msa_pkg;

    // ------------------------------------------------------------
    // Program space map
    // ------------------------------------------------------------
    localparam logic [23:0] MSA_RESET_VEC      = 24'h000000;
    localparam logic [23:0] MSA_RESET_TGT      = 24'h000002;
    localparam logic [23:0] MSA_IVT_A_LO       = 24'h000004;
    localparam logic [23:0] MSA_IVT_A_HI       = 24'h0000ff;
    localparam logic [23:0] MSA_IVT_B_LO       = 24'h000104;
    localparam logic [23:0] MSA_IVT_B_HI       = 24'h0001ff;
    localparam logic [23:0] MSA_EE_LO          = 24'h7ffe00;
    localparam logic [23:0] MSA_EE_HI          = 24'h7fffff;
    localparam logic [23:0] MSA_CFG_LO         = 24'hf80000;
    localparam logic [23:0] MSA_CFG_HI         = 24'hf8000e;
    localparam int          MSA_EE_WORDS       = 256;
    localparam int          MSA_CFG_WORDS      = 7;
    localparam logic [23:0] MSA_PC_STEP        = 24'h000002;

    // ------------------------------------------------------------
    // Data space map
    // ------------------------------------------------------------
    localparam int          MSA_EA_W           = 16;
    localparam int          MSA_WINDOW_BIT     = 15;
    localparam logic [15:0] MSA_SFR_HI         = 16'h07ff;
    localparam logic [15:0] MSA_NEAR_HI        = 16'h1fff;
    localparam int          MSA_NEAR_W         = 13;
    localparam int          MSA_RAM_WORDS      = 1024;
    localparam logic [15:0] MSA_RAM_BASE       = 16'h0800;
    localparam int          MSA_WIN_EN_BIT     = 2;
    localparam logic [15:0] MSA_CTRL_RST       = 16'h0000;

    // Pointer step for post-increment or post-decrement
    typedef enum logic [1:0] {
        MSA_PTR_NONE = 2'b00,
        MSA_PTR_INC  = 2'b01,
        MSA_PTR_DEC  = 2'b10
    } msa_ptr_mode_e;

    // Program fetch sequencing
    typedef enum logic [1:0] {
        MSA_PC_HOLD  = 2'b00,
        MSA_PC_NEXT  = 2'b01,
        MSA_PC_BACK  = 2'b10,
        MSA_PC_LOAD  = 2'b11
    } msa_pc_op_e;

endpackage : msa_pkg

// ---- msa_byte_lane.sv ----
`timescale 1ns/10ps
module msa_byte_lane
    import msa_pkg::*;
(
    input  wire logic        byte_op,
    input  wire logic        addr_lsb,
    input  wire logic        wr_req,
    input  wire logic        misaligned,
    input  wire logic [15:0] wr_data,
    input  wire logic [15:0] rd_word,
    output logic      [1:0]  strobe,
    output logic      [15:0] wr_lanes,
    output logic      [15:0] rd_value
);

    // Lane strobes; a misaligned word write drives none
    always_comb begin
        strobe = 2'b00;
        if (wr_req && !misaligned) begin
            if (byte_op) begin
                strobe = addr_lsb ? 2'b10 : 2'b01;
            end else begin
                strobe = 2'b11;
            end
        end
    end

    // Byte data replicated onto both lanes; the strobe picks the addressed one
    assign wr_lanes = byte_op ? {wr_data[7:0], wr_data[7:0]} : wr_data;

    // Byte reads pick a half of the word and place it low
    assign rd_value = byte_op ? {8'h00, (addr_lsb ? rd_word[15:8] : rd_word[7:0])}
                              : rd_word;

endmodule : msa_byte_lane

// ---- msa_access_unit.sv ----
`timescale 1ns/10ps
// Contract
// - Program word is lower even, upper odd
// - Program counter steps by two only
// - Reset fetch starts at address zero
// - Two vector tables decoded in program space
// - Data EEPROM 256 words at program top
// - Seven configuration words at fixed addresses
// - Separate read and write address generators
// - Sixteen-bit byte effective addresses
// - Bit 15 selects program window
// - Unimplemented data reads return zero
// - Low byte even, high byte odd
// - Post-increment by one byte, two word
// - Byte read selects half onto low lane
// - Byte write updates only addressed half
// - Odd word access raises address trap
// - Misaligned write suppressed before trap
// - Byte load keeps register high byte
// - Sign extend and zero extend operations
// - Low direct region via 13-bit field
// - Move direct field spans whole space
// - Unused special register reads zero
// - Control bit 2 enables program window
module msa_access_unit
    import msa_pkg::*;
#(
    parameter int RAM_WORDS = MSA_RAM_WORDS
)(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Program fetch control
    input  wire logic [1:0]  pc_op,
    input  wire logic [23:0] pc_load,
    output logic      [23:0] pc_q,
    // Program address classification
    input  wire logic [23:0] prog_addr,
    output logic             prog_upper_word,
    output logic             prog_in_vectors,
    output logic             prog_in_eeprom,
    output logic      [7:0]  eeprom_index,
    output logic             prog_in_config,
    output logic      [2:0]  config_index,
    output logic             prog_is_reset_slot,
    // Control register bit
    input  wire logic        ctrl_wr,
    input  wire logic [15:0] ctrl_wdata,
    output logic      [15:0] ctrl_rdata,
    output logic             program_window_enable,
    // Read address generator
    input  wire logic        rd_req,
    input  wire logic        rd_byte,
    input  wire logic        rd_direct,
    input  wire logic        rd_short,
    input  wire logic [15:0] rd_direct_addr,
    input  wire logic [1:0]  rd_ptr_mode,
    input  wire logic [15:0] source_pointer_reg,
    output logic      [15:0] rd_pointer_next,
    output logic      [15:0] operand_byte_address,
    output logic             rd_window_sel,
    output logic      [15:0] rd_data,
    // Write address generator
    input  wire logic        wr_req,
    input  wire logic        wr_byte,
    input  wire logic        wr_direct,
    input  wire logic        wr_short,
    input  wire logic [15:0] wr_direct_addr,
    input  wire logic [1:0]  wr_ptr_mode,
    input  wire logic [15:0] dest_pointer_reg,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] wr_pointer_next,
    output logic      [15:0] wr_byte_address,
    output logic      [1:0]  wr_strobe,
    // Special register area read data from the core
    input  wire logic [15:0] sfr_rdata,
    input  wire logic        sfr_hit,
    // Working register byte load and extension
    input  wire logic [15:0] wreg_old,
    input  wire logic        sign_extend_op,
    input  wire logic        zero_extend_op,
    input  wire logic        byte_load,
    output logic      [15:0] wreg_new,
    // Exception request
    output logic             addr_trap
);

    localparam int RAM_AW = $clog2(RAM_WORDS);

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------

    // Reset fetch at zero; steps are always two
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pc_q <= MSA_RESET_VEC;
        end else begin
            case (msa_pc_op_e'(pc_op))
                MSA_PC_NEXT: pc_q <= pc_q + MSA_PC_STEP;
                MSA_PC_BACK: pc_q <= pc_q - MSA_PC_STEP;
                MSA_PC_LOAD: pc_q <= {pc_load[23:1], 1'b0};
                default:     pc_q <= pc_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program space decode
    // ------------------------------------------------------------

    // Odd address is the upper word of an instruction
    assign prog_upper_word    = prog_addr[0];
    assign prog_is_reset_slot = (prog_addr == MSA_RESET_VEC)
                              || (prog_addr == MSA_RESET_TGT);
    assign prog_in_vectors    = ((prog_addr >= MSA_IVT_A_LO) && (prog_addr <= MSA_IVT_A_HI))
                              || ((prog_addr >= MSA_IVT_B_LO) && (prog_addr <= MSA_IVT_B_HI));

    // EEPROM words, one per even address pair
    assign prog_in_eeprom = (prog_addr >= MSA_EE_LO) && (prog_addr <= MSA_EE_HI);
    assign eeprom_index   = prog_addr[8:1];

    // Configuration word slots; the first one is alone at offset zero
    always_comb begin
        prog_in_config = 1'b0;
        config_index   = 3'h0;
        if ((prog_addr >= MSA_CFG_LO) && (prog_addr <= MSA_CFG_HI) && !prog_addr[0]) begin
            case (prog_addr[3:1])
                3'h0:    begin prog_in_config = 1'b1; config_index = 3'h0; end
                3'h2:    begin prog_in_config = 1'b1; config_index = 3'h1; end
                3'h3:    begin prog_in_config = 1'b1; config_index = 3'h2; end
                3'h4:    begin prog_in_config = 1'b1; config_index = 3'h3; end
                3'h5:    begin prog_in_config = 1'b1; config_index = 3'h4; end
                3'h6:    begin prog_in_config = 1'b1; config_index = 3'h5; end
                3'h7:    begin prog_in_config = 1'b1; config_index = 3'h6; end
                default: begin prog_in_config = 1'b0; config_index = 3'h0; end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------

    logic window_en_q;

    // Window enable bit, cleared by reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            window_en_q <= MSA_CTRL_RST[MSA_WIN_EN_BIT];
        end else if (ctrl_wr) begin
            window_en_q <= ctrl_wdata[MSA_WIN_EN_BIT];
        end
    end

    assign program_window_enable = window_en_q;

    // Other bits read as zero
    always_comb begin
        ctrl_rdata                 = 16'h0000;
        ctrl_rdata[MSA_WIN_EN_BIT] = window_en_q;
    end

    // ------------------------------------------------------------
    // Address generators
    // ------------------------------------------------------------

    // Short direct field reaches only the low direct region
    function automatic logic [15:0] msa_ea(input logic        direct,
                                           input logic        short_fld,
                                           input logic [15:0] dir_addr,
                                           input logic [15:0] ptr);
        logic [15:0] ea;
        ea = ptr;
        if (direct) begin
            ea = short_fld ? {3'b000, dir_addr[MSA_NEAR_W-1:0]}
                           : dir_addr;
        end
        return ea;
    endfunction : msa_ea

    // Post-modify by one for bytes, two for words
    function automatic logic [15:0] msa_step(input logic [1:0]  mode,
                                             input logic        byte_op,
                                             input logic [15:0] ptr);
        logic [15:0] d;
        d = byte_op ? 16'h0001 : 16'h0002;
        case (msa_ptr_mode_e'(mode))
            MSA_PTR_INC: return ptr + d;
            MSA_PTR_DEC: return ptr - d;
            default:     return ptr;
        endcase
    endfunction : msa_step

    // Independent read and write generators
    assign operand_byte_address = msa_ea(rd_direct, rd_short, rd_direct_addr,
                                         source_pointer_reg);
    assign wr_byte_address      = msa_ea(wr_direct, wr_short, wr_direct_addr,
                                         dest_pointer_reg);
    assign rd_pointer_next      = msa_step(rd_ptr_mode, rd_byte, source_pointer_reg);
    assign wr_pointer_next      = msa_step(wr_ptr_mode, wr_byte, dest_pointer_reg);

    // Upper half goes to the window only when enabled
    assign rd_window_sel = operand_byte_address[MSA_WINDOW_BIT] && window_en_q;

    // ------------------------------------------------------------
    // Data RAM and read path
    // ------------------------------------------------------------

    logic [7:0]  ram_lo [RAM_WORDS];
    logic [7:0]  ram_hi [RAM_WORDS];
    logic [15:0] rd_word;
    logic [15:0] rd_off;
    logic [15:0] wr_off;
    logic        rd_in_ram;
    logic        wr_in_ram;
    logic        rd_misaligned;
    logic        wr_misaligned;
    logic [1:0]  lane_strobe;
    logic [15:0] lane_wdata;

    assign rd_off    = operand_byte_address - MSA_RAM_BASE;
    assign wr_off    = wr_byte_address - MSA_RAM_BASE;
    assign rd_in_ram = !operand_byte_address[MSA_WINDOW_BIT]
                     && (operand_byte_address > MSA_SFR_HI)
                     && (rd_off[15:1] < 15'(RAM_WORDS));
    assign wr_in_ram = !wr_byte_address[MSA_WINDOW_BIT]
                     && (wr_byte_address > MSA_SFR_HI)
                     && (wr_off[15:1] < 15'(RAM_WORDS));

    assign rd_misaligned = rd_req && !rd_byte && operand_byte_address[0];
    assign wr_misaligned = wr_req && !wr_byte && wr_byte_address[0];

    // Word source: special registers, RAM, or zero
    always_comb begin
        rd_word = 16'h0000;
        if (!operand_byte_address[MSA_WINDOW_BIT] && (operand_byte_address <= MSA_SFR_HI)) begin
            rd_word = sfr_hit ? sfr_rdata : 16'h0000;
        end else if (rd_in_ram) begin
            rd_word = {ram_hi[rd_off[RAM_AW:1]], ram_lo[rd_off[RAM_AW:1]]};
        end
    end

    msa_byte_lane u_lane (
        .byte_op    (wr_req ? wr_byte : rd_byte),
        .addr_lsb   (wr_req ? wr_byte_address[0] : operand_byte_address[0]),
        .wr_req     (wr_req && wr_in_ram),
        .misaligned (wr_misaligned),
        .wr_data    (wr_data),
        .rd_word    (rd_word),
        .strobe     (lane_strobe),
        .wr_lanes   (lane_wdata),
        .rd_value   ()
    );

    // Read data placement does not depend on a concurrent write
    assign rd_data = rd_byte ? {8'h00, (operand_byte_address[0] ? rd_word[15:8]
                                                                : rd_word[7:0])}
                             : rd_word;
    assign wr_strobe = lane_strobe;

    // Per-lane RAM writes; misaligned word writes never reach here
    always_ff @(posedge core_clk) begin
        if (lane_strobe[0]) begin
            ram_lo[wr_off[RAM_AW:1]] <= lane_wdata[7:0];
        end
        if (lane_strobe[1]) begin
            ram_hi[wr_off[RAM_AW:1]] <= lane_wdata[15:8];
        end
    end

    // ------------------------------------------------------------
    // Working register update and trap
    // ------------------------------------------------------------

    // Byte load and extension of a working register
    always_comb begin
        wreg_new = wreg_old;
        if (sign_extend_op) begin
            wreg_new = {{8{wreg_old[7]}}, wreg_old[7:0]};
        end else if (zero_extend_op) begin
            wreg_new = {8'h00, wreg_old[7:0]};
        end else if (byte_load) begin
            wreg_new = {wreg_old[15:8], rd_data[7:0]};
        end
    end

    // Trap held for as long as the misaligned request is present
    assign addr_trap = rd_misaligned || wr_misaligned;

endmodule : msa_access_unit

// ---- msa_access_unit_sva.sv ----
`timescale 1ns/10ps
module msa_access_unit_sva
    import msa_pkg::*;
#(
    parameter int RAM_WORDS = MSA_RAM_WORDS
)(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [1:0]  pc_op,
    input wire logic [23:0] pc_q,
    input wire logic        ctrl_wr,
    input wire logic [15:0] ctrl_wdata,
    input wire logic        program_window_enable,
    input wire logic        rd_req,
    input wire logic        rd_byte,
    input wire logic [1:0]  rd_ptr_mode,
    input wire logic [15:0] source_pointer_reg,
    input wire logic [15:0] rd_pointer_next,
    input wire logic [15:0] operand_byte_address,
    input wire logic [15:0] rd_data,
    input wire logic        wr_req,
    input wire logic        wr_byte,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] wr_byte_address,
    input wire logic [1:0]  wr_strobe,
    input wire logic        addr_trap
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    localparam logic [16:0] RAM_END = 17'(MSA_RAM_BASE) + 17'(2 * RAM_WORDS);
    logic rd_odd_w;
    logic wr_odd_w;
    logic wr_in_ram;
    // Misaligned word requests and writable span
    assign rd_odd_w  = rd_req && !rd_byte && operand_byte_address[0];
    assign wr_odd_w  = wr_req && !wr_byte && wr_byte_address[0];
    assign wr_in_ram = wr_byte_address >= MSA_RAM_BASE && {1'b0, wr_byte_address} < RAM_END;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_PC_RESET: assert property (disable iff (1'b0) sys_rst |=> pc_q == 24'h000000)
        else $error("pc not zero after reset");
    AST_PC_STEP: assert property (pc_op == 2'd1 |=> pc_q == $past(pc_q) + 24'h000002)
        else $error("pc step is not two");
    AST_TRAP: assert property (addr_trap == (rd_odd_w || wr_odd_w))
        else $error("trap does not match odd word access");
    AST_TRAP_PULSE: assert property (
        addr_trap && !$past(addr_trap) ##1 !(rd_odd_w || wr_odd_w) |-> !addr_trap)
        else $error("trap held without cause");
    AST_WR_SUPPRESS: assert property (wr_odd_w |-> wr_strobe == 2'b00)
        else $error("misaligned write not suppressed");
    AST_BYTE_STROBE: assert property (wr_req && wr_byte && wr_in_ram
        |-> wr_strobe == (wr_byte_address[0] ? 2'b10 : 2'b01))
        else $error("byte strobe on wrong lane");
    AST_WORD_STROBE: assert property (wr_req && !wr_byte && !wr_byte_address[0]
        && wr_in_ram |-> wr_strobe == 2'b11)
        else $error("word write lacks both strobes");
    AST_WIN_ZERO: assert property (rd_req && operand_byte_address[15] |-> rd_data == 16'h0000)
        else $error("window area read not zero");
    AST_UNIMPL: assert property (rd_req && !operand_byte_address[15]
        && {1'b0, operand_byte_address} >= RAM_END |-> rd_data == 16'h0000)
        else $error("unimplemented read not zero");
    AST_BYTE_LANE: assert property (rd_req && rd_byte |-> rd_data[15:8] == 8'h00)
        else $error("byte read upper lane not clear");
    AST_PTR_INC: assert property (rd_ptr_mode == MSA_PTR_INC
        |-> rd_pointer_next == source_pointer_reg + (rd_byte ? 16'h0001 : 16'h0002))
        else $error("pointer increment wrong");
    AST_WIN_BIT: assert property (ctrl_wr |=> program_window_enable == $past(ctrl_wdata[2]))
        else $error("window enable not written");
    AST_RAM_WORD: assert property ((wr_strobe == 2'b11 ##1 rd_req && !rd_byte && !wr_req
        && operand_byte_address == $past(wr_byte_address)) |-> rd_data == $past(wr_data))
        else $error("word write not read back");

    // Main scenarios reached
    COV_BYTE_WR: cover property (wr_strobe == 2'b10);
    COV_TRAP_WR: cover property (wr_odd_w && addr_trap);
    COV_WIN_RD: cover property (rd_req && operand_byte_address[15] && program_window_enable);
endmodule : msa_access_unit_sva

bind msa_access_unit msa_access_unit_sva #(.RAM_WORDS(RAM_WORDS)) msa_access_unit_sva_i (
    .core_clk, .sys_rst, .pc_op, .pc_q, .ctrl_wr, .ctrl_wdata, .program_window_enable,
    .rd_req, .rd_byte, .rd_ptr_mode, .source_pointer_reg, .rd_pointer_next,
    .operand_byte_address, .rd_data, .wr_req, .wr_byte, .wr_data, .wr_byte_address,
    .wr_strobe, .addr_trap);

// ---- msa_core_model.sv ----
`timescale 1ns/10ps
module msa_core_model
    import msa_pkg::*;
#(
    parameter logic [15:0] REG_ADDR = 16'h0044,
    parameter logic [15:0] REG_VAL  = 16'h5c3a
)(
    input  wire logic [15:0] operand_byte_address,
    input  wire logic        core_clk,
    output logic      [15:0] sfr_rdata,
    output logic             sfr_hit
);
    logic [15:0] noise_q = 16'h0000;
    // Changing pattern so a stale value never looks valid
    always_ff @(posedge core_clk) begin
        noise_q <= noise_q + 16'h9e37;
    end
    // One implemented core register, every other address unused
    always_comb begin
        sfr_hit   = operand_byte_address[15:1] == REG_ADDR[15:1];
        sfr_rdata = sfr_hit ? REG_VAL : noise_q;
    end
endmodule : msa_core_model

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench
    import msa_pkg::*;
;
    localparam int RAM_W = 64;
    logic        core_clk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0;
    logic [1:0]  pc_op = 2'd0, rd_ptr_mode = 2'd0, wr_ptr_mode = 2'd0, wr_strobe;
    logic [23:0] pc_load = '0, prog_addr = '0, pc_q;
    logic        rd_req = 0, rd_byte = 0, rd_direct = 1, rd_short = 0;
    logic        wr_req = 0, wr_byte = 0, wr_direct = 1, wr_short = 0;
    logic        sign_extend_op = 0, zero_extend_op = 0, byte_load = 0, sfr_hit, addr_trap;
    logic [15:0] ctrl_wdata = '0, rd_direct_addr = '0, source_pointer_reg = '0;
    logic [15:0] wr_direct_addr = '0, dest_pointer_reg = '0, wr_data = '0, wreg_old = '0;
    logic [15:0] sfr_rdata, ctrl_rdata, rd_pointer_next, operand_byte_address, rd_data;
    logic [15:0] wr_pointer_next, wr_byte_address, wreg_new;
    logic        prog_upper_word, prog_in_vectors, prog_in_eeprom, prog_in_config;
    logic        prog_is_reset_slot, program_window_enable, rd_window_sel;
    logic [7:0]  eeprom_index;
    logic [2:0]  config_index;
    int          error_cnt = 0, num_checks = 0;

    always #25 core_clk = ~core_clk;

    msa_access_unit #(.RAM_WORDS(RAM_W)) msa_access_unit_i (.core_clk, .sys_rst, .pc_op,
        .pc_load, .pc_q, .prog_addr, .prog_upper_word, .prog_in_vectors, .prog_in_eeprom,
        .eeprom_index, .prog_in_config, .config_index, .prog_is_reset_slot, .ctrl_wr,
        .ctrl_wdata, .ctrl_rdata, .program_window_enable, .rd_req, .rd_byte, .rd_direct,
        .rd_short, .rd_direct_addr, .rd_ptr_mode, .source_pointer_reg, .rd_pointer_next,
        .operand_byte_address, .rd_window_sel, .rd_data, .wr_req, .wr_byte, .wr_direct,
        .wr_short, .wr_direct_addr, .wr_ptr_mode, .dest_pointer_reg, .wr_data,
        .wr_pointer_next, .wr_byte_address, .wr_strobe, .sfr_rdata, .sfr_hit, .wreg_old,
        .sign_extend_op, .zero_extend_op, .byte_load, .wreg_new, .addr_trap);
    msa_core_model msa_core_model_i (.operand_byte_address, .core_clk, .sfr_rdata, .sfr_hit);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd_at(input logic [15:0] a, input logic b);
        @(negedge core_clk);
        wr_req = 0;
        rd_req = 1;
        rd_byte = b;
        rd_direct_addr = a;
        #5;
    endtask : rd_at
    task automatic wr_at(input logic [15:0] a, input logic b, input logic [15:0] d);
        @(negedge core_clk);
        rd_req = 0;
        wr_req = 1;
        wr_byte = b;
        wr_direct_addr = a;
        wr_data = d;
        #5;
    endtask : wr_at
    task automatic ctl(input logic [15:0] d);
        @(negedge core_clk);
        ctrl_wr = 1;
        ctrl_wdata = d;
        @(negedge core_clk);
        ctrl_wr = 0;
    endtask : ctl

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_pc();
        chk("pc_reset", 24'h000000, pc_q);
        pc_op = 2'd1;
        repeat (2) @(negedge core_clk);
        chk("pc_up", 24'h000004, pc_q);
        pc_op = 2'd2;
        @(negedge core_clk);
        chk("pc_down", 24'h000002, pc_q);
        pc_op = 2'd3;
        pc_load = 24'h000107;
        @(negedge core_clk);
        pc_op = 2'd0;
        chk("pc_load", 24'h000106, pc_q);
    endtask : t_pc
    task automatic t_prog();
        logic [23:0] a [11] = '{24'h000000, 24'h000005, 24'h0000fe, 24'h000100, 24'h0001ff,
            24'h000200, 24'h7ffe00, 24'h7ffffe, 24'hf80000, 24'hf80002, 24'hf8000e};
        logic [12:0] e [11] = '{13'h0100, 13'h1800, 13'h0800, 13'h0000, 13'h1800,
            13'h0000, 13'h0400, 13'h04ff, 13'h0200, 13'h0000, 13'h0206};
        for (int i = 0; i < 11; i++) begin
            @(negedge core_clk);
            prog_addr = a[i];
            #5;
            chk("prog_map", 24'(e[i]), 24'({prog_upper_word, prog_in_vectors, prog_in_eeprom,
                prog_in_config, prog_is_reset_slot, prog_in_eeprom ? eeprom_index
                : {5'h00, prog_in_config ? config_index : 3'h0}}));
        end
    endtask : t_prog
    task automatic t_bytes();
        wr_at(16'h0801, 1, 16'h005a);
        chk("strobe_hi", 24'h2, 24'(wr_strobe));
        wr_at(16'h0800, 1, 16'h00a5);
        chk("strobe_lo", 24'h1, 24'(wr_strobe));
        rd_at(16'h0800, 0);
        chk("word", 24'h5aa5, 24'(rd_data));
        rd_at(16'h0801, 1);
        chk("byte_hi", 24'h005a, 24'(rd_data));
        rd_at(16'h0045, 1);
        chk("sfr_byte", 24'h005c, 24'(rd_data));
        rd_at(16'h0400, 0);
        chk("sfr_unused", 24'h0, 24'(rd_data));
    endtask : t_bytes
    task automatic t_trap();
        wr_at(16'h0802, 0, 16'h1234);
        chk("strobe_w", 24'h3, 24'({addr_trap, wr_strobe}));
        rd_at(16'h0802, 0);
        chk("word_back", 24'h1234, 24'(rd_data));
        wr_at(16'h0803, 0, 16'hffff);
        chk("odd_wr", 24'h4, 24'({addr_trap, wr_strobe}));
        rd_at(16'h0802, 0);
        chk("kept", 24'h01234, {7'h0, addr_trap, rd_data});
        rd_at(16'h0803, 0);
        chk("odd_rd", 24'h1, 24'(addr_trap));
    endtask : t_trap
    task automatic t_space();
        rd_at(16'(32'h0800 + 2 * RAM_W), 0);
        chk("past_ram", 24'h0, 24'(rd_data));
        rd_at(16'h7fff, 1);
        chk("top_byte", 24'h0, 24'(rd_data));
        ctl(16'hffff);
        chk("ctrl", 24'h10004, {7'h0, program_window_enable, ctrl_rdata});
        rd_at(16'h8000, 0);
        chk("win_on", 24'h10000, {7'h0, rd_window_sel, rd_data});
        rd_at(16'h7ffe, 0);
        chk("win_low", 24'h0, 24'(rd_window_sel));
        ctl(16'hfffb);
        rd_at(16'h8000, 0);
        chk("win_off", 24'h0, 24'(rd_window_sel));
    endtask : t_space
    task automatic t_addr();
        @(negedge core_clk);
        rd_direct = 0;
        wr_direct = 0;
        rd_ptr_mode = MSA_PTR_INC;
        wr_ptr_mode = MSA_PTR_INC;
        source_pointer_reg = 16'h0810;
        dest_pointer_reg = 16'h0820;
        rd_byte = 1;
        #5;
        chk("ptr_b", 24'h0811, 24'(rd_pointer_next));
        chk("ea", 24'h0810, 24'(operand_byte_address));
        chk("wptr", 24'h0822, 24'(wr_pointer_next));
        @(negedge core_clk);
        rd_byte = 0;
        #5;
        chk("ptr_w", 24'h0812, 24'(rd_pointer_next));
        @(negedge core_clk);
        rd_direct = 1;
        wr_direct = 1;
        rd_short = 1;
        rd_direct_addr = 16'hffff;
        #5;
        chk("short", 24'h1fff, 24'(operand_byte_address));
        @(negedge core_clk);
        rd_short = 0;
        #5;
        chk("full", 24'hffff, 24'(operand_byte_address));
        @(negedge core_clk);
        wreg_old = 16'h3480;
        sign_extend_op = 1;
        #5;
        chk("sext", 24'hff80, 24'(wreg_new));
        @(negedge core_clk);
        sign_extend_op = 0;
        zero_extend_op = 1;
        #5;
        chk("zext", 24'h0080, 24'(wreg_new));
        @(negedge core_clk);
        zero_extend_op = 0;
        byte_load = 1;
        #5;
        chk("bload", 24'h3400, 24'(wreg_new));
    endtask : t_addr

    // Watchdog ends a hung run
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 0;
        t_pc();
        t_prog();
        t_bytes();
        t_trap();
        t_space();
        t_addr();
        summarize();
    end
endmodule : testbench
